// *** core/dbg_comms_pkg.sv ***
// Notes on behaviour
// - Set abort status flag when a break or watch match causes an abort.
// - External abort on same access wins over a watch, a break still raises prefetch abort; abort status flag left unchanged.
// - Processor reads and writes abort status flag by coprocessor transfers.
// - Processor write to outbound data register sets write-pending flag.
// - Debugger read of outbound register clears write-pending flag.
// - Outbound scan carries a validity flag in the lowest address bit.
// - Debugger write into inbound register sets read-valid flag.
// - Processor read of inbound register clears read-valid flag.
// - Processor accesses still accepted while debug port reset is low.
// - During debug port reset control low bits read binary 10.
// - During debug port reset both handshake outputs are zero at once.
// - After release, control low bits read 00 and transmit-empty is one.
// - Monitor-enable bit 4 turns break into prefetch, watch into data abort.
// - Monitor matching uses no data values or ranges.
// - Watch register write during access suppresses that unit that cycle.
// - Watch abort taken one execute cycle after the triggering access.
// - Monitor watch abort link is last unexecuted instruction plus four.
// - Break matches fetch address only; prefetch abort link as normal.
// - Control bit 1 is write-pending, bit 0 read-valid, status only.
// - Debugger write to control register clears read-valid flag.
`default_nettype none
package dbg_comms_pkg;
   localparam logic [1:0] CP_REG_CONTROL = 2'h0;
   localparam logic [1:0] CP_REG_DATA = 2'h1;
   localparam logic [1:0] CP_REG_STATUS = 2'h2;
   localparam int CTRL_READ_VALID_BIT = 0;
   localparam int CTRL_WRITE_PENDING_BIT = 1;
   localparam int CTRL_VERSION_LSB = 28;
   localparam int MONITOR_ENABLE_BIT = 4;
   localparam logic [31:0] LINK_OFFSET = 32'h00000004;
   localparam logic [31:0] DATA_RESET = 32'h00000000;
   localparam int SYNC_STAGES = 3;
   localparam int WATCH_DELAY_CYCLES = 1;
endpackage
`default_nettype wire

// *** core/pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_sync
   import dbg_comms_pkg::*;
#(
   parameter int WIDTH = 1
)
(
   input wire logic clock_in, // core clock
   input wire logic reset_in, // synchronous reset
   input wire logic [WIDTH-1:0] pin_in, // asynchronous inputs
   output logic [WIDTH-1:0] level_out, // debounced level
   output logic [WIDTH-1:0] rise_out // one-cycle rising pulse
);
   logic [WIDTH-1:0] stage [SYNC_STAGES];
   logic [WIDTH-1:0] next_level;

   if (WIDTH < 1)
   begin : g_width_check
      $error("pin_sync width must be positive");
   end

   // Change accepted once second and third stages agree
   always_comb
   begin
      next_level = level_out;
      for (int i = 0; i < WIDTH; i++)
      begin
         if (stage[1][i] == stage[2][i])
         begin
            next_level[i] = stage[2][i];
         end
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         stage[0] <= '0;
         stage[1] <= '0;
         stage[2] <= '0;
         level_out <= '0;
         rise_out <= '0;
      end
      else
      begin
         stage[0] <= pin_in;
         stage[1] <= stage[0];
         stage[2] <= stage[1];
         level_out <= next_level;
         rise_out <= next_level & ~level_out;
      end
   end
endmodule
`default_nettype wire

// *** core/debug_comms_mailbox.sv ***
`timescale 1ns/1ps
`default_nettype none
module debug_comms_mailbox
   import dbg_comms_pkg::*;
#(
   parameter logic [3:0] VERSION_CODE = 4'h5 // arbitrary value
)
(
   input wire logic clock_in, // core clock, 200 MHz
   input wire logic reset_in, // synchronous reset, active high
   input wire logic debug_port_reset_n_in, // debug port reset, low active
   input wire logic cp_read_in, // coprocessor read transfer strobe
   input wire logic cp_write_in, // coprocessor write transfer strobe
   input wire logic [1:0] cp_reg_in, // coprocessor register number
   input wire logic [31:0] cp_wdata_in, // coprocessor write data
   output logic [31:0] cp_rdata_out, // coprocessor read data
   output logic cp_ack_out, // transfer accepted pulse
   input wire logic tck_in, // scan clock from debugger
   input wire logic scan_update_in, // update strobe level (scan domain)
   input wire logic scan_capture_in, // capture strobe level (scan domain)
   input wire logic [1:0] scan_sel_in, // 0 control, 1 data
   input wire logic scan_write_in, // update is a write
   input wire logic [31:0] scan_wdata_in, // scanned-in data
   output logic [31:0] scan_rdata_out, // captured data
   output logic scan_valid_out, // validity flag, address bit 0
   output logic receive_valid_out, // inbound data waiting
   output logic transmit_empty_out, // outbound register free
   input wire logic monitor_enable_in, // control register bit 4
   input wire logic break_match_in, // fetch address comparator match
   input wire logic watch_match_in, // data address comparator match
   input wire logic watch_reg_write_in, // watch unit register updated
   input wire logic access_active_in, // memory access in progress
   input wire logic external_abort_in, // external abort on same access
   input wire logic [31:0] unexec_pc_in, // last instruction not executed
   output logic prefetch_abort_out, // breakpoint prefetch abort
   output logic data_abort_out, // watchpoint data abort
   output logic halt_request_out, // halt mode debug entry
   output logic [31:0] abort_link_out // link value for watch abort
);
   logic [31:0] outbound_data;
   logic [31:0] inbound_data;
   logic write_pending;
   logic read_valid;
   logic debug_abort_flag;
   logic watch_stage;
   logic [31:0] next_outbound;
   logic [31:0] next_inbound;
   logic next_write_pending;
   logic next_read_valid;
   logic next_abort_flag;
   logic next_watch_stage;
   logic [31:0] next_rdata;
   logic next_prefetch;
   logic next_data_abort;
   logic next_halt;
   logic [31:0] next_link;
   logic [2:0] sync_level;
   logic [2:0] sync_rise;
   logic tck_level;
   logic port_reset_n;
   logic update_edge;
   logic capture_edge;
   logic watch_hit;
   logic abort_event;

   // Scan strobes sampled by the core clock
   pin_sync #(
      .WIDTH(3)
   ) u_sync (
      .clock_in(clock_in),
      .reset_in(reset_in),
      .pin_in({debug_port_reset_n_in, scan_capture_in, scan_update_in}),
      .level_out(sync_level),
      .rise_out(sync_rise)
   );
   pin_sync #(
      .WIDTH(1)
   ) u_tck (
      .clock_in(clock_in),
      .reset_in(reset_in),
      .pin_in(tck_in),
      .level_out(tck_level),
      .rise_out()
   );
   assign port_reset_n = sync_level[2] & debug_port_reset_n_in;
   // Strobes act only while the scan clock rests low between shifts
   assign update_edge = sync_rise[0] && !tck_level;
   assign capture_edge = sync_rise[1] && !tck_level;

   // Suppression while the watch unit is rewritten mid-access
   assign watch_hit = watch_match_in
      && !(watch_reg_write_in && access_active_in);

   // A debug abort that the status flag records in this cycle
   assign abort_event = monitor_enable_in
      && (watch_stage || (break_match_in && !external_abort_in));

   function automatic logic [31:0] control_word(input logic wp,
                                                input logic rv);
      control_word = {VERSION_CODE, 26'h0, wp, rv};
   endfunction

   always_comb
   begin
      next_outbound = outbound_data;
      next_inbound = inbound_data;
      next_write_pending = write_pending;
      next_read_valid = read_valid;
      next_abort_flag = debug_abort_flag;
      next_watch_stage = 1'b0;
      next_rdata = cp_rdata_out;
      next_prefetch = 1'b0;
      next_data_abort = 1'b0;
      next_halt = 1'b0;
      next_link = abort_link_out;
      // Debugger side
      if (update_edge && scan_write_in && scan_sel_in == CP_REG_DATA)
      begin
         next_inbound = scan_wdata_in;
         next_read_valid = 1'b1;
      end
      else if (update_edge && scan_write_in && scan_sel_in == CP_REG_CONTROL)
      begin
         next_read_valid = 1'b0;
      end
      if (capture_edge && scan_sel_in == CP_REG_DATA)
      begin
         next_write_pending = 1'b0;
      end
      // Processor side, accepted regardless of debug port reset
      if (cp_write_in && cp_reg_in == CP_REG_DATA)
      begin
         next_outbound = cp_wdata_in;
         next_write_pending = 1'b1;
      end
      if (cp_read_in)
      begin
         if (cp_reg_in == CP_REG_CONTROL)
         begin
            if (!port_reset_n)
            begin
               next_rdata = control_word(1'b1, 1'b0);
            end
            else
            begin
               next_rdata = control_word(write_pending, read_valid);
            end
         end
         else if (cp_reg_in == CP_REG_DATA)
         begin
            next_rdata = inbound_data;
            next_read_valid = 1'b0;
         end
         else if (cp_reg_in == CP_REG_STATUS)
         begin
            next_rdata = {31'h0, debug_abort_flag};
         end
         else
         begin
            next_rdata = 32'h00000000;
         end
      end
      // Break and watch handling, address-only comparators feed us
      if (monitor_enable_in)
      begin
         if (break_match_in)
         begin
            next_prefetch = 1'b1;
         end
         // External abort on the matching access wins over the watch
         next_watch_stage = watch_hit && !external_abort_in;
         if (watch_stage)
         begin
            next_data_abort = 1'b1;
            next_link = unexec_pc_in + LINK_OFFSET;
         end
         if (abort_event)
         begin
            next_abort_flag = 1'b1;
         end
      end
      else
      begin
         next_halt = break_match_in || watch_hit;
      end
      if (cp_write_in && cp_reg_in == CP_REG_STATUS)
      begin
         // Hardware set wins over a clearing write in the same cycle
         next_abort_flag = cp_wdata_in[0] || abort_event;
      end
      // Held empty so release reads 00 at once; reads show 10 meanwhile
      if (!port_reset_n)
      begin
         next_write_pending = 1'b0;
         next_read_valid = 1'b0;
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         outbound_data <= DATA_RESET;
         inbound_data <= DATA_RESET;
         write_pending <= 1'b1;
         read_valid <= 1'b0;
         debug_abort_flag <= 1'b0;
         watch_stage <= 1'b0;
         cp_rdata_out <= DATA_RESET;
         cp_ack_out <= 1'b0;
         prefetch_abort_out <= 1'b0;
         data_abort_out <= 1'b0;
         halt_request_out <= 1'b0;
         abort_link_out <= DATA_RESET;
         scan_rdata_out <= DATA_RESET;
         scan_valid_out <= 1'b0;
      end
      else
      begin
         outbound_data <= next_outbound;
         inbound_data <= next_inbound;
         write_pending <= next_write_pending;
         read_valid <= next_read_valid;
         debug_abort_flag <= next_abort_flag;
         watch_stage <= next_watch_stage;
         cp_rdata_out <= next_rdata;
         cp_ack_out <= cp_read_in || cp_write_in;
         prefetch_abort_out <= next_prefetch;
         data_abort_out <= next_data_abort;
         halt_request_out <= next_halt;
         abort_link_out <= next_link;
         if (capture_edge)
         begin
            scan_rdata_out <= (scan_sel_in == CP_REG_DATA) ? outbound_data
               : control_word(write_pending, read_valid);
            scan_valid_out <= write_pending && port_reset_n;
         end
      end
   end

   // Handshake outputs forced low at once by debug port reset
   always_ff @(posedge clock_in or negedge debug_port_reset_n_in)
   begin
      if (!debug_port_reset_n_in)
      begin
         receive_valid_out <= 1'b0;
         transmit_empty_out <= 1'b0;
      end
      else
      begin
         receive_valid_out <= next_read_valid && !reset_in;
         transmit_empty_out <= !next_write_pending && !reset_in;
      end
   end

   reset_read_a: assert property (
      @(posedge clock_in) disable iff (reset_in)
      cp_read_in && cp_reg_in == CP_REG_CONTROL && !port_reset_n
      |=> cp_rdata_out[1:0] == 2'h2)
      else $error("control low bits wrong in debug reset");

   read_clear_a: assert property (
      @(posedge clock_in) disable iff (reset_in)
      cp_read_in && cp_reg_in == CP_REG_DATA && port_reset_n
      |=> !read_valid)
      else $error("read-valid not cleared by processor read");

   write_set_a: assert property (
      @(posedge clock_in) disable iff (reset_in)
      cp_write_in && cp_reg_in == CP_REG_DATA && port_reset_n
      |=> write_pending)
      else $error("write-pending not set by processor write");

   abort_set_a: assert property (
      @(posedge clock_in) disable iff (reset_in)
      monitor_enable_in && break_match_in && !external_abort_in
      |=> debug_abort_flag)
      else $error("abort status not set on breakpoint abort");

   ext_priority_a: assert property (
      @(posedge clock_in) disable iff (reset_in)
      external_abort_in && !watch_stage
      && !(cp_write_in && cp_reg_in == CP_REG_STATUS)
      |=> $stable(debug_abort_flag))
      else $error("abort status changed on external abort");

   flag_sticky_a: assert property (
      @(posedge clock_in) disable iff (reset_in)
      debug_abort_flag && !(cp_write_in && cp_reg_in == CP_REG_STATUS)
      |=> debug_abort_flag)
      else $error("abort status cleared without write");

   port_reset_a: assert property (
      @(posedge clock_in) disable iff (reset_in)
      !debug_port_reset_n_in |-> !receive_valid_out && !transmit_empty_out)
      else $error("handshake outputs high in debug reset");

   watch_delay_a: assert property (
      @(posedge clock_in) disable iff (reset_in)
      monitor_enable_in && watch_hit && !external_abort_in
      ##1 monitor_enable_in
      |=> data_abort_out)
      else $error("watch abort not one cycle after access");

   link_value_a: assert property (
      @(posedge clock_in) disable iff (reset_in)
      data_abort_out |-> abort_link_out == $past(unexec_pc_in) + LINK_OFFSET)
      else $error("watch abort link wrong");

   suppress_a: assert property (
      @(posedge clock_in) disable iff (reset_in)
      watch_reg_write_in && access_active_in |=> !watch_stage)
      else $error("watch match not suppressed during update");
endmodule
`default_nettype wire

// *** testbench/debug_probe_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module debug_probe_model
(
   output logic tck_out, // scan clock, still between frames
   output logic update_out, // update strobe level
   output logic capture_out, // capture strobe level
   output logic [1:0] sel_out, // scan target
   output logic write_out, // update is a write
   output logic [31:0] wdata_out // scanned-in word
);
   initial
   begin
      {tck_out, update_out, capture_out, write_out} = 4'h0;
      sel_out = 2'h0;
      wdata_out = 32'h0;
   end
   // One frame of four scan clocks; strobe raised on a falling edge
   task automatic frame(input logic cap, input logic [1:0] sel,
                        input logic wr, input logic [31:0] d);
      sel_out = sel;
      write_out = wr;
      wdata_out = d;
      for (int i = 0; i < 4; i++)
      begin
         #40 tck_out = 1'b1;
         #40 tck_out = 1'b0;
         if (i == 1) {capture_out, update_out} = {cap, ~cap};
         if (i == 3) {capture_out, update_out} = 2'h0;
      end
      // Released lines show the inverse, not the last value
      sel_out = ~sel;
      wdata_out = ~d;
      #100;
   endtask
endmodule
`default_nettype wire

// *** testbench/debug_comms_mailbox_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module debug_comms_mailbox_tb;
   import dbg_comms_pkg::*;
   localparam logic [3:0] VER = 4'h9; // arbitrary value
   logic clock_in = 1'b0, reset_in = 1'b1, prst_n = 1'b1;
   logic rd = 1'b0, wr = 1'b0, mon = 1'b0, brk = 1'b0, wat = 1'b0;
   logic wreg = 1'b0, acc = 1'b0, ext = 1'b0;
   logic [1:0] rg = 2'h0, sel;
   logic [31:0] wd = 32'h0, pc = 32'h0, rdat, sdat, link, sw, d, r;
   logic ack, tck, upd, cap, swr, sval, rxv, txe, pab, dab, hlt;
   int miscompares = 0, samples_checked = 0, np, nd, nh;
   initial forever #2.5 clock_in = ~clock_in;
   debug_probe_model u_debug_probe_model (.tck_out(tck),
      .update_out(upd), .capture_out(cap), .sel_out(sel),
      .write_out(swr), .wdata_out(sw));
   debug_comms_mailbox #(.VERSION_CODE(VER)) u_debug_comms_mailbox (
      .clock_in(clock_in), .reset_in(reset_in),
      .debug_port_reset_n_in(prst_n), .cp_read_in(rd), .cp_write_in(wr),
      .cp_reg_in(rg), .cp_wdata_in(wd), .cp_rdata_out(rdat),
      .cp_ack_out(ack), .tck_in(tck), .scan_update_in(upd),
      .scan_capture_in(cap), .scan_sel_in(sel), .scan_write_in(swr),
      .scan_wdata_in(sw), .scan_rdata_out(sdat), .scan_valid_out(sval),
      .receive_valid_out(rxv), .transmit_empty_out(txe),
      .monitor_enable_in(mon), .break_match_in(brk),
      .watch_match_in(wat), .watch_reg_write_in(wreg),
      .access_active_in(acc), .external_abort_in(ext),
      .unexec_pc_in(pc), .prefetch_abort_out(pab),
      .data_abort_out(dab), .halt_request_out(hlt),
      .abort_link_out(link));
   function automatic logic [31:0] ctl(input logic w, input logic v);
      return {VER, 26'h0, w, v};
   endfunction
   task automatic finish_test;
      $display("miscompares %0d samples_checked %0d", miscompares,
               samples_checked);
      if (miscompares == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic check_word(input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         $display("unexpected at %0t: expected %h got %h", $time, e, g);
         miscompares++;
      end
   endtask
   task automatic check_bit(input logic e, input logic g);
      check_word({31'h0, e}, {31'h0, g});
   endtask
   // Coprocessor transfer; result and acknowledge land one cycle later
   task automatic cp(input logic w, input logic [1:0] n,
                     input logic [31:0] v, output logic [31:0] q);
      @(posedge clock_in);
      {wr, rd, rg, wd} <= {w, ~w, n, v};
      @(posedge clock_in);
      {wr, rd} <= 2'h0;
      #1 check_bit(1'b1, ack);
      q = rdat;
   endtask
   task automatic abort(input logic [5:0] c, input logic [31:0] p);
      @(posedge clock_in);
      {mon, brk, wat, wreg, acc, ext} <= c;
      pc <= p;
      @(posedge clock_in);
      {brk, wat, wreg, acc, ext} <= 5'h0;
      {np, nd, nh} = 0;
      repeat (6)
      begin
         #1 {np, nd, nh} = {np + pab, nd + dab, nh + hlt};
         if (dab === 1'b1) r = link;
         @(posedge clock_in);
      end
   endtask
   initial
   begin
      void'($urandom(58381));
      repeat (12) @(posedge clock_in);
      reset_in <= 1'b0;
      @(posedge clock_in);
      prst_n <= 1'b0;
      #1 check_bit(1'b0, rxv);
      check_bit(1'b0, txe);
      cp(1'b0, CP_REG_CONTROL, 32'h0, r);
      check_word(ctl(1'b1, 1'b0), r);
      prst_n <= 1'b1;
      repeat (6) @(posedge clock_in);
      cp(1'b0, CP_REG_CONTROL, 32'h0, r);
      check_word(ctl(1'b0, 1'b0), r);
      check_bit(1'b1, txe);
      for (int k = 0; k < 4; k++)
      begin
         d = (k == 0) ? 32'hFFFFFFFF : $urandom;
         cp(1'b1, CP_REG_DATA, d, r);
         cp(1'b0, CP_REG_CONTROL, 32'h0, r);
         check_word(ctl(1'b1, 1'b0), r);
         check_bit(1'b0, txe);
         u_debug_probe_model.frame(1'b1, 2'h1, 1'b0, $urandom);
         check_word(d, sdat);
         check_bit(1'b1, sval);
         cp(1'b0, CP_REG_CONTROL, 32'h0, r);
         check_word(ctl(1'b0, 1'b0), r);
         u_debug_probe_model.frame(1'b1, 2'h1, 1'b0, $urandom);
         check_bit(1'b0, sval);
         d = (k == 1) ? 32'h0 : $urandom;
         check_bit(1'b0, rxv);
         u_debug_probe_model.frame(1'b0, 2'h1, 1'b1, d);
         for (int t = 0; t < 100 && rxv !== 1'b1; t++) @(posedge clock_in);
         if (rxv !== 1'b1)
         begin
            miscompares++;
            finish_test();
         end
         cp(1'b0, CP_REG_CONTROL, 32'h0, r);
         check_word(ctl(1'b0, 1'b1), r);
         cp(1'b0, CP_REG_DATA, 32'h0, r);
         check_word(d, r);
         cp(1'b0, CP_REG_CONTROL, 32'h0, r);
         check_word(ctl(1'b0, 1'b0), r);
      end
      u_debug_probe_model.frame(1'b0, 2'h1, 1'b1, $urandom);
      u_debug_probe_model.frame(1'b0, 2'h0, 1'b1, $urandom);
      cp(1'b0, CP_REG_CONTROL, 32'h0, r);
      check_word(ctl(1'b0, 1'b0), r);
      cp(1'b0, 2'h3, 32'h0, r);
      check_word(32'h0, r);
      abort(6'h30, 32'h0);
      check_word(32'h1, np);
      cp(1'b0, CP_REG_STATUS, 32'h0, r);
      check_word(32'h1, r);
      abort(6'h10, 32'h0);
      check_word(32'h1, nh);
      check_word(32'h0, np);
      cp(1'b0, CP_REG_STATUS, 32'h0, r);
      check_word(32'h1, r);
      cp(1'b1, CP_REG_STATUS, 32'h0, r);
      cp(1'b0, CP_REG_STATUS, 32'h0, r);
      check_word(32'h0, r);
      abort(6'h29, $urandom);
      cp(1'b0, CP_REG_STATUS, 32'h0, r);
      check_word(32'h0, r);
      abort(6'h2E, $urandom);
      check_word(32'h0, nd);
      d = $urandom & 32'hFFFFFFFC;
      abort(6'h28, d);
      check_word(32'h1, nd);
      check_word(d + LINK_OFFSET, r);
      cp(1'b1, CP_REG_STATUS, 32'h1, r);
      cp(1'b0, CP_REG_STATUS, 32'h0, r);
      check_word(32'h1, r);
      finish_test();
   end
endmodule
`default_nettype wire
